// >>> common/pcg_regs.vh
// register map, field positions, reset values and loop constants of the clock generator
// Notes on behaviour
// [RULE_01] base clock is crystal or vco, halved
// [RULE_02] crystal buffered twice into final reference
// [RULE_03] crystal runs only while oscillator enabled
// [RULE_04] vco divided by N gives feedback
// [RULE_05] phase detector emits up/down correction pulses
// [RULE_06] lock detector compares feedback and reference rates
// [RULE_07] vco centre equals L times 4.9152 MHz
// [RULE_08] acquisition mode keeps select bit clear
// [RULE_09] select bit set means tracking mode
// [RULE_10] automatic mode: detector drives select bit
// [RULE_11] select bit set/cleared by track tolerances
// [RULE_12] lock flag set/cleared by lock tolerances
// [RULE_13] lock change requests interrupt when enabled
// [RULE_14] manual mode: software writes select bit
// [RULE_15] manual mode: no lock flag, no interrupt
// [RULE_16] software clears select before pll on
// [RULE_17] software waits acquisition time before tracking
// [RULE_18] software waits lock time before vco select
// [RULE_19] software selects vco only after lock
// [RULE_20] switch holds output, waits three+three cycles
// [RULE_21] refuse illegal power/select combinations
// [RULE_22] N of zero acts as one
// [RULE_23] L of zero disables pll, forces crystal
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

`define PCG_OFF_CTRL 8'h00
`define PCG_OFF_BW 8'h04
`define PCG_OFF_PROG 8'h08
`define PCG_OFF_FREQ 8'h0C

`define PCG_CTRL_IRQEN 7
`define PCG_CTRL_POWER 5
`define PCG_CTRL_SRCSEL 4
`define PCG_BW_AUTO 7
`define PCG_BW_LOCK 6
`define PCG_BW_TRACK 5

`define PCG_CTRL_RST 8'h00
`define PCG_BW_RST 8'h00
`define PCG_PROG_RST 8'h00

// frequencies in units of 100 Hz
`define PCG_CLK_FREQ 21'h1312D0
`define PCG_NOM_FREQ 21'h00C000
`define PCG_XTAL_FREQ 21'h009C40
`define PCG_FREQ_CAP 21'h1312CF

`define PCG_STEP_WIDE 21'h000100
`define PCG_STEP_TRK 21'h000008
`define PCG_WIN 8'h20
`define PCG_TOL_TRK 8'h01
`define PCG_TOL_UNT 8'h03
`define PCG_TOL_LOCK 8'h00
`define PCG_TOL_UNL 8'h02
`define PCG_SW_WAIT 2'h3

`endif

// >>> src/pcg_nco.v
// numerically controlled oscillator producing one-cycle tick enables
`timescale 1ns/1ns
`default_nettype none
`include "pcg_regs.vh"
module pcg_nco (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire en,
  input wire [20:0] freq,
  // tick
  output reg tick
);
  reg [20:0] acc_r;
  wire [21:0] sum = {1'b0, acc_r} + {1'b0, freq};

  // freq must stay below the clock rate, else ticks are lost
  always @(posedge clk) begin
    if (!rst_n || !en) begin
      acc_r <= 21'h000000;
      tick <= 1'b0;
    end else if (sum >= {1'b0, `PCG_CLK_FREQ}) begin
      acc_r <= sum[20:0] - `PCG_CLK_FREQ;
      tick <= 1'b1;
    end else begin
      acc_r <= sum[20:0];
      tick <= 1'b0;
    end
  end
endmodule // pcg_nco
`default_nettype wire

// >>> src/pcg_mod_div.v
// modulo divider of vco ticks into feedback ticks
`timescale 1ns/1ns
`default_nettype none
module pcg_mod_div (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire en,
  input wire [3:0] modN,
  input wire inTick,
  // output
  output reg outTick
);
  reg [3:0] cnt_r;
  wire [3:0] nEff = (modN == 4'h0) ? 4'h1 : modN; // [RULE_22]

  always @(posedge clk) begin
    if (!rst_n || !en) begin
      cnt_r <= 4'h0;
      outTick <= 1'b0;
    end else if (inTick && (cnt_r >= nEff - 4'h1)) begin
      cnt_r <= 4'h0;
      outTick <= 1'b1; // [RULE_04]
    end else begin
      if (inTick)
        cnt_r <= cnt_r + 4'h1;
      outTick <= 1'b0;
    end
  end
endmodule // pcg_mod_div
`default_nettype wire

// >>> src/pcg_clock_gen.v
// clock generator control: reference, feedback, phase/lock detect, selector, apb registers
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "pcg_regs.vh"
module pcg_clock_gen (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // from system integration module
  input wire oscEnableFromSim,
  // clock enables out
  output reg crystalClock,
  output reg pllRefClock,
  output reg finalRefClock,
  output reg vcoClock,
  output reg vcoFeedbackClock,
  output reg baseClockOut,
  // loop
  output reg pumpUp,
  output reg pumpDown,
  output reg pllIrqReq
);
  localparam SEL_RUN = 1'b0;
  localparam SEL_WAIT = 1'b1;
  localparam [7:0] CTRL_RST = `PCG_CTRL_RST;
  localparam [7:0] BW_RST = `PCG_BW_RST;
  localparam [7:0] PROG_RST = `PCG_PROG_RST;

  // registers
  reg pllIrqEnable_r;
  reg pllPowerOn_r;
  reg baseClockSelect_r;
  reg autoBw_r;
  reg acquireTrackSelect_r;
  reg lock_r;
  reg [3:0] modN_r;
  reg [3:0] linL_r;
  reg [20:0] vcoFreq_r;
  reg [20:0] vcoFreq_nxt;
  reg upPend_r;
  reg dnPend_r;
  reg [7:0] winCnt_r;
  reg [7:0] fbCnt_r;
  reg selState_r;
  reg selVco_r;
  reg [1:0] xCnt_r;
  reg [1:0] vCnt_r;

  wire xtalTick;
  wire vcoTick;
  wire fbTick;
  wire lNonZero = (linL_r != 4'h0);
  wire pllRun = pllPowerOn_r && lNonZero && oscEnableFromSim; // [RULE_23]
  wire [20:0] centre = {17'h00000, linL_r} * `PCG_NOM_FREQ; // [RULE_07]
  wire [20:0] fMin = {1'b0, centre[20:1]};
  wire [20:0] fDbl = {centre[19:0], 1'b0};
  wire [20:0] fMax = (fDbl > `PCG_FREQ_CAP) ? `PCG_FREQ_CAP : fDbl;
  wire [20:0] step = acquireTrackSelect_r ? `PCG_STEP_TRK : `PCG_STEP_WIDE; // [RULE_09]

  // crystal runs only while enabled by the system module
  pcg_nco xtalOsc (
    .clk(clk),
    .rst_n(rst_n),
    .en(oscEnableFromSim), // [RULE_03]
    .freq(`PCG_XTAL_FREQ),
    .tick(xtalTick)
  );

  pcg_nco vcoOsc (
    .clk(clk),
    .rst_n(rst_n),
    .en(pllRun),
    .freq(vcoFreq_r),
    .tick(vcoTick)
  );

  pcg_mod_div fbDiv (
    .clk(clk),
    .rst_n(rst_n),
    .en(pllRun),
    .modN(modN_r),
    .inTick(vcoTick),
    .outTick(fbTick)
  );

  // reference buffers and tick outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      crystalClock <= 1'b0;
      pllRefClock <= 1'b0;
      finalRefClock <= 1'b0;
      vcoClock <= 1'b0;
      vcoFeedbackClock <= 1'b0;
    end else begin
      crystalClock <= xtalTick;
      pllRefClock <= xtalTick; // [RULE_02]
      finalRefClock <= pllRefClock; // [RULE_02]
      vcoClock <= vcoTick;
      vcoFeedbackClock <= fbTick;
    end
  end

  // phase detector: up on reference first, down on feedback first
  always @(posedge clk) begin
    if (!rst_n || !pllRun) begin
      upPend_r <= 1'b0;
      dnPend_r <= 1'b0;
    end else begin
      if ((upPend_r || finalRefClock) && (dnPend_r || fbTick)) begin
        upPend_r <= 1'b0; // [RULE_05]
        dnPend_r <= 1'b0;
      end else begin
        upPend_r <= upPend_r || finalRefClock; // [RULE_05]
        dnPend_r <= dnPend_r || fbTick;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
    end else begin
      pumpUp <= upPend_r;
      pumpDown <= dnPend_r;
    end
  end

  // loop filter: step size follows the acquire/track mode
  always @* begin
    vcoFreq_nxt = vcoFreq_r;
    if (upPend_r && !dnPend_r)
      vcoFreq_nxt = (vcoFreq_r + step > fMax) ? fMax : vcoFreq_r + step; // [RULE_08]
    else if (dnPend_r && !upPend_r)
      vcoFreq_nxt = (vcoFreq_r < fMin + step) ? fMin : vcoFreq_r - step;
  end

  always @(posedge clk) begin
    if (!rst_n)
      vcoFreq_r <= 21'h000000;
    else if (!pllRun)
      vcoFreq_r <= (centre > `PCG_FREQ_CAP) ? `PCG_FREQ_CAP : centre;
    else
      vcoFreq_r <= vcoFreq_nxt;
  end

  // lock detector: count feedback ticks over a window of reference ticks
  wire winEnd = finalRefClock && (winCnt_r == `PCG_WIN - 8'h01);
  wire [7:0] fbSum = (fbCnt_r == 8'hFF || !fbTick) ? fbCnt_r : fbCnt_r + 8'h01;
  wire [7:0] diff = (fbSum > `PCG_WIN) ? fbSum - `PCG_WIN : `PCG_WIN - fbSum;

  always @(posedge clk) begin
    if (!rst_n || !pllRun) begin
      winCnt_r <= 8'h00;
      fbCnt_r <= 8'h00;
    end else if (winEnd) begin
      winCnt_r <= 8'h00;
      fbCnt_r <= 8'h00;
    end else begin
      if (finalRefClock)
        winCnt_r <= winCnt_r + 8'h01;
      fbCnt_r <= fbSum; // [RULE_06]
    end
  end

  // apb decode
  wire apbDo = psel && penable && pready;
  wire apbWr = apbDo && pwrite;
  wire wrCtrl = apbWr && (paddr == `PCG_OFF_CTRL);
  wire wrBw = apbWr && (paddr == `PCG_OFF_BW);
  wire wrProg = apbWr && (paddr == `PCG_OFF_PROG);
  wire mapped = (paddr == `PCG_OFF_CTRL) || (paddr == `PCG_OFF_BW) ||
                (paddr == `PCG_OFF_PROG) || (paddr == `PCG_OFF_FREQ);
  wire newOn = pwdata[`PCG_CTRL_POWER];
  wire newSel = pwdata[`PCG_CTRL_SRCSEL];
  wire onChg = newOn != pllPowerOn_r;
  wire selChg = newSel != baseClockSelect_r;
  // both changing in one write is refused as a whole
  wire both = onChg && selChg;
  wire onOk = onChg && !both && !(!newOn && baseClockSelect_r); // [RULE_21]
  wire selOk = selChg && !both && !(newSel && (!pllPowerOn_r || !lNonZero)); // [RULE_21]

  // control and program registers
  always @(posedge clk) begin
    if (!rst_n) begin
      pllIrqEnable_r <= CTRL_RST[`PCG_CTRL_IRQEN];
      pllPowerOn_r <= 1'b0;
      baseClockSelect_r <= 1'b0;
      modN_r <= PROG_RST[7:4];
      linL_r <= PROG_RST[3:0];
    end else begin
      if (wrCtrl) begin
        pllIrqEnable_r <= pwdata[`PCG_CTRL_IRQEN];
        if (onOk)
          pllPowerOn_r <= newOn;
        if (selOk)
          baseClockSelect_r <= newSel; // [RULE_01]
      end
      if (!lNonZero)
        baseClockSelect_r <= 1'b0; // [RULE_23]
      if (wrProg) begin
        modN_r <= pwdata[7:4];
        linL_r <= pwdata[3:0];
      end
    end
  end

  // bandwidth register, acquire/track select and lock flag
  always @(posedge clk) begin
    if (!rst_n) begin
      autoBw_r <= BW_RST[`PCG_BW_AUTO];
      acquireTrackSelect_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      if (wrBw)
        autoBw_r <= pwdata[`PCG_BW_AUTO];
      if (!autoBw_r) begin
        lock_r <= 1'b0; // [RULE_15]
        if (wrBw)
          acquireTrackSelect_r <= pwdata[`PCG_BW_TRACK]; // [RULE_14]
      end else if (!pllRun) begin
        acquireTrackSelect_r <= 1'b0; // [RULE_10]
        lock_r <= 1'b0;
      end else if (winEnd) begin
        if (diff <= `PCG_TOL_TRK)
          acquireTrackSelect_r <= 1'b1; // [RULE_11]
        else if (diff > `PCG_TOL_UNT)
          acquireTrackSelect_r <= 1'b0; // [RULE_11]
        if (diff <= `PCG_TOL_LOCK)
          lock_r <= 1'b1; // [RULE_12]
        else if (diff > `PCG_TOL_UNL)
          lock_r <= 1'b0; // [RULE_12]
      end
    end
  end

  // lock change interrupt request, one cycle per toggle
  reg lockPrev_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      lockPrev_r <= 1'b0;
      pllIrqReq <= 1'b0;
    end else begin
      lockPrev_r <= lock_r;
      pllIrqReq <= (lock_r != lockPrev_r) && pllIrqEnable_r && autoBw_r; // [RULE_13] [RULE_15]
    end
  end

  // base clock selector: hold output during source change
  wire selTick = selVco_r ? vcoTick : xtalTick;
  wire vDone = (vCnt_r == `PCG_SW_WAIT) || !pllRun;
  wire reqVco = baseClockSelect_r && lNonZero;

  always @(posedge clk) begin
    if (!rst_n) begin
      selState_r <= SEL_RUN;
      selVco_r <= 1'b0;
      xCnt_r <= 2'h0;
      vCnt_r <= 2'h0;
      baseClockOut <= 1'b0;
    end else begin
      case (selState_r)
        SEL_RUN: begin
          xCnt_r <= 2'h0;
          vCnt_r <= 2'h0;
          if (reqVco != selVco_r)
            selState_r <= SEL_WAIT; // [RULE_20]
          else if (selTick)
            baseClockOut <= !baseClockOut; // [RULE_01]
        end
        SEL_WAIT: begin
          if (xtalTick && xCnt_r != `PCG_SW_WAIT)
            xCnt_r <= xCnt_r + 2'h1; // [RULE_20]
          if (vcoTick && vCnt_r != `PCG_SW_WAIT)
            vCnt_r <= vCnt_r + 2'h1; // [RULE_20]
          // a stopped crystal would hang here; the system module keeps it on only while oscReq is high
          if (xCnt_r == `PCG_SW_WAIT && vDone) begin
            selVco_r <= reqVco;
            selState_r <= SEL_RUN;
          end
        end
        default: selState_r <= SEL_RUN;
      endcase
    end
  end

  // apb answer: one wait state, registered read data
  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `PCG_OFF_CTRL: prdata <= {24'h000000, pllIrqEnable_r, 1'b0, pllPowerOn_r,
                                    baseClockSelect_r, 4'h0};
          `PCG_OFF_BW: prdata <= {24'h000000, autoBw_r, lock_r, acquireTrackSelect_r,
                                  5'h00};
          `PCG_OFF_PROG: prdata <= {24'h000000, modN_r, linL_r};
          `PCG_OFF_FREQ: prdata <= {11'h000, vcoFreq_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // pcg_clock_gen
`default_nettype wire

// >>> tb/pcg_clock_gen_properties.sv
// concurrent checks on the clock generator control ports
`timescale 1ns/1ns
`default_nettype none
module pcg_clock_gen_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // clocks
  input wire logic oscEnableFromSim,
  input wire logic crystalClock,
  input wire logic pllRefClock,
  input wire logic finalRefClock,
  input wire logic vcoClock,
  input wire logic vcoFeedbackClock,
  input wire logic baseClockOut,
  input wire logic pllIrqReq,
  // loop correction
  input wire logic pumpUp,
  input wire logic pumpDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sAccWait;
    psel && penable && !pready;
  endsequence
  sequence sOscOff;
    !oscEnableFromSim [*3];
  endsequence
  AST_ONE_WAIT: assert property (sAccWait |=> pready)
    else $error("ready not one cycle after access");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_REF_BUF: assert property (crystalClock == pllRefClock)
    else $error("reference not buffered crystal");
  AST_REF_DLY: assert property (pllRefClock |=> finalRefClock)
    else $error("final reference missing");
  AST_OSC_GATE: assert property (sOscOff |-> !crystalClock && !vcoClock)
    else $error("clock running with oscillator off");
  AST_FB_NEEDS_VCO: assert property (vcoFeedbackClock |-> vcoClock || $past(vcoClock))
    else $error("feedback without vco tick");
  AST_BASE_SRC: assert property ($changed(baseClockOut) |-> crystalClock || vcoClock)
    else $error("base clock moved without source tick");
  AST_PUMP_EXCL: assert property (!(pumpUp && pumpDown))
    else $error("up and down correction together");
  AST_IRQ_PULSE: assert property (pllIrqReq |=> !pllIrqReq)
    else $error("interrupt request longer than one cycle");
endmodule // pcg_clock_gen_props
bind pcg_clock_gen pcg_clock_gen_props chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .oscEnableFromSim(oscEnableFromSim),
  .crystalClock(crystalClock), .pllRefClock(pllRefClock), .finalRefClock(finalRefClock),
  .vcoClock(vcoClock), .vcoFeedbackClock(vcoFeedbackClock), .baseClockOut(baseClockOut),
  .pllIrqReq(pllIrqReq), .pumpUp(pumpUp), .pumpDown(pumpDown));
`default_nettype wire

// >>> tb/pcg_sim_model.sv
// system integration side: gives oscillator enable, counts base clock edges
`timescale 1ns/1ns
`default_nettype none
module pcg_sim_model (
  // clock
  input wire logic clk,
  // control and observation
  input wire logic oscReq,
  input wire logic baseClockOut,
  output wire logic oscEnableFromSim,
  output int edges
);
  logic osc_r = 1'b0;
  logic last_r = 1'b0;
  int edges_r = 0;
  assign oscEnableFromSim = osc_r;
  assign edges = edges_r;
  always @(posedge clk) begin
    osc_r <= oscReq;
    last_r <= baseClockOut;
    edges_r <= edges_r + int'(baseClockOut !== last_r);
  end
endmodule // pcg_sim_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench of the clock generator control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic err;
  } pcg_row_t;
  // manual order: select clear before power on, track before vco
  localparam pcg_row_t ROWS [20] = '{
    '{1'b0,8'h00,8'h00,1'b0}, '{1'b0,8'h04,8'h00,1'b0}, '{1'b0,8'h08,8'h00,1'b0},
    '{1'b0,8'h10,8'h00,1'b1}, '{1'b1,8'h00,8'h10,1'b0}, '{1'b0,8'h00,8'h00,1'b0},
    '{1'b1,8'h08,8'h54,1'b0}, '{1'b0,8'h08,8'h54,1'b0}, '{1'b1,8'h00,8'h30,1'b0},
    '{1'b0,8'h00,8'h00,1'b0}, '{1'b1,8'h00,8'h20,1'b0}, '{1'b0,8'h00,8'h20,1'b0},
    '{1'b1,8'h04,8'h20,1'b0}, '{1'b0,8'h04,8'h20,1'b0}, '{1'b1,8'h00,8'h30,1'b0},
    '{1'b0,8'h00,8'h30,1'b0}, '{1'b1,8'h00,8'h10,1'b0}, '{1'b0,8'h00,8'h30,1'b0},
    '{1'b1,8'h08,8'h50,1'b0}, '{1'b0,8'h00,8'h20,1'b0}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic oscReq = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, oscEnableFromSim, crystalClock, pllRefClock, finalRefClock;
  logic vcoClock, vcoFeedbackClock, baseClockOut, pumpUp, pumpDown, pllIrqReq;
  int edges, errors = 0, n_tests = 0, cyc = 0, irqs = 0, xt, vt, ft, ed, pu;
  always #4 clk = ~clk;
  pcg_clock_gen dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscEnableFromSim(oscEnableFromSim), .crystalClock(crystalClock),
    .pllRefClock(pllRefClock), .finalRefClock(finalRefClock), .vcoClock(vcoClock),
    .vcoFeedbackClock(vcoFeedbackClock), .baseClockOut(baseClockOut), .pumpUp(pumpUp),
    .pumpDown(pumpDown), .pllIrqReq(pllIrqReq));
  pcg_sim_model sim_u (.clk(clk), .oscReq(oscReq), .baseClockOut(baseClockOut),
    .oscEnableFromSim(oscEnableFromSim), .edges(edges));
  task automatic final_report;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] near(input int a, input int b, input int t);
    return (a - b <= t && b - a <= t) ? 32'h1 : 32'h0;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic measure(input int n);
    int e0;
    e0 = edges;
    xt = 0;
    vt = 0;
    ft = 0;
    pu = 0;
    repeat (n) begin
      @(posedge clk);
      pu += int'(pumpUp || pumpDown);
      xt += int'(crystalClock);
      vt += int'(vcoClock);
      ft += int'(vcoFeedbackClock);
    end
    ed = edges - e0;
  endtask
  // free-running watchdog also counts lock interrupts
  always @(posedge clk) begin
    cyc++;
    if (rst_n && pllIrqReq === 1'b1) irqs <= irqs + 1;
    if (cyc == 40000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    int i;
    logic [31:0] q;
    logic e;
    repeat (12) @(posedge clk);
    chk("outputs in reset", {28'h0, baseClockOut, pready, pllIrqReq, crystalClock}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 20; i++) begin
      apb(ROWS[i].w, ROWS[i].a, {24'h0, ROWS[i].d}, q, e);
      chk("pslverr", {31'h0, e}, {31'h0, ROWS[i].err});
      if (!ROWS[i].w && !ROWS[i].err) chk("prdata", q, {24'h0, ROWS[i].d});
      // software settling time after each write
      if (ROWS[i].w) repeat (100) @(posedge clk);
    end
    chk("irq in manual", 32'(irqs), 32'h0);
    apb(1'b1, 8'h08, 32'h04, q, e);
    measure(2000);
    chk("N zero ratio", near(ft, vt, 1), 32'h1);
    apb(1'b1, 8'h08, 32'h34, q, e);
    measure(2000);
    chk("N three ratio", near(3 * ft, vt, 3), 32'h1);
    chk("crystal base", near(ed, xt, 1), 32'h1);
    chk("pump active", 32'(pu > 0), 32'h1);
    oscReq <= 1'b0;
    repeat (10) @(posedge clk);
    measure(500);
    chk("osc off", 32'(xt + vt), 32'h0);
    // stopped loop sits at its centre: 4 x 49152 in 100 Hz units
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk("vco centre", q, 32'h00030000);
    oscReq <= 1'b1;
    apb(1'b1, 8'h08, 32'hB9, q, e);
    apb(1'b1, 8'h04, 32'h80, q, e);
    apb(1'b1, 8'h00, 32'hA0, q, e);
    i = 0;
    while (irqs == 0 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    chk("lock irq", 32'(irqs > 0), 32'h1);
    // acquire bit written low in auto mode must not stick
    apb(1'b1, 8'h04, 32'h80, q, e);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("auto lock track", q & 32'hE0, 32'hE0);
    apb(1'b1, 8'h00, 32'hB0, q, e);
    repeat (200) @(posedge clk);
    measure(2000);
    chk("vco base", near(ed, vt, 2), 32'h1);
    // mid-run reset must drop control and bandwidth registers back, lock flag too
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("outputs in reset 2", {28'h0, baseClockOut, pready, pllIrqReq, finalRefClock}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl after reset", q, 32'h0);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("bw after reset", q, 32'h0);
    final_report;
  end
endmodule // testbench
`default_nettype wire
